// File: logic/sensor_fifo_core.sv
`include "sensor_fifo_consts.svh"
`default_nettype none
// Summary of operation
// (RULE_01) Eleven-bit threshold, unit one 16-bit word
// (RULE_02) Watermark when count reaches or passes threshold
// (RULE_03) Limit bit makes threshold the capacity
// (RULE_04) Without limit, store past threshold until full
// (RULE_05) Smart-full rises one word before capacity
// (RULE_06) FIFO mode with limit: watermark never set
// (RULE_07) Continuous with limit: smart-full then watermark
// (RULE_08) High-only keeps upper byte of motion data
// (RULE_09) High-only set: six interleaved accel/gyro bytes
// (RULE_10) High-only uses set one, host zeroes set two
// (RULE_11) Time/step record: fixed six-byte order
// (RULE_12) Time/step record goes in set four
// (RULE_13) Trigger select: buffer rate or each step
// (RULE_14) Host enables features before operating mode
// (RULE_15) Temperature record in set four, bytes 3-4
// (RULE_16) Host sets temperature options before mode
// (RULE_17) Three-bit operating mode selects behaviour
// (RULE_18) Flags follow every write and every read
module sensor_fifo_core
#(
   parameter int DEPTH = `SF_DEPTH
)
(
   input  wire logic                 clk,
   input  wire logic                 srst,
   input  wire logic [10:0]          threshold_level,    // RULE_01
   input  wire logic                 limit_at_threshold,
   input  wire logic                 high_part_only,
   input  wire logic [2:0]           set1_decimation,
   input  wire logic [2:0]           set4_decimation,
   input  wire logic                 time_step_record_en,
   input  wire logic                 time_step_trigger_sel,
   input  wire logic                 temp_record_en,
   input  wire logic                 data_valid_sel,
   input  wire logic [2:0]           operating_mode,
   input  wire logic                 rate_tick,
   input  wire logic                 step_detect,
   input  wire logic                 word_read,
   input  wire sensor_fifo_pkg::sensor_sample_t sample,
   output logic [15:0]               word_count_out,
   output logic                      watermark_flag,
   output logic                      smart_full_flag,
   output logic                      word_strobe,
   output logic [15:0]               word_data
);
   // The count is twelve bits, so no buffer beyond the full size
   if (DEPTH < 2 || DEPTH > `SF_DEPTH)
   begin : g_depth_check
      $error("DEPTH out of range");
   end

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [1:0] tick_s1_reg, tick_s2_reg, tick_d_reg;
   logic [1:0] tick_next;
   // Two stages; edge detect only on the second stage
   always_comb
   begin
      tick_next = {step_detect, rate_tick};
   end
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         tick_s1_reg <= 2'h0;
         tick_s2_reg <= 2'h0;
         tick_d_reg  <= 2'h0;
      end
      else
      begin
         tick_s1_reg <= tick_next;
         tick_s2_reg <= tick_s1_reg;
         tick_d_reg  <= tick_s2_reg;
      end
   end
   logic rate_edge, step_edge;
   assign rate_edge = tick_s2_reg[0] & ~tick_d_reg[0];
   assign step_edge = tick_s2_reg[1] & ~tick_d_reg[1];

   // Decimation compare used for set one and set four
   function automatic logic dec_hit(input logic [2:0] dec,
                                    input logic [2:0] cnt);
      dec_hit = (dec != `SF_DEC_OFF) && (cnt == 3'(dec - 3'h1));
   endfunction

   // ------------------------------------------------------------
   // Record sequencer
   // ------------------------------------------------------------
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_SET1 = 2'b01,
      ST_SET4 = 2'b11
   } seq_t;
   seq_t       state_reg, state_next;
   logic [2:0] byte_reg, byte_next;
   logic [2:0] dec1_reg, dec1_next;
   logic [2:0] dec4_reg, dec4_next;
   logic       want4_reg, want4_next;
   logic [7:0] lo_reg, lo_next;
   logic       half_reg, half_next;
   sensor_fifo_pkg::sensor_sample_t smp_reg, smp_next;
   sensor_fifo_pkg::set4_kind_t kind;
   logic [7:0] pick;
   logic       push;
   logic [15:0] push_word;
   logic       time_trig;
   logic       set4_on;

   // Set-four content: record wins over temperature
   assign kind = time_step_record_en ? sensor_fifo_pkg::SET4_TIME :
                 (temp_record_en ? sensor_fifo_pkg::SET4_TEMP :
                  sensor_fifo_pkg::SET4_NONE);                 // RULE_15
   assign set4_on = (kind != sensor_fifo_pkg::SET4_NONE);
   // Step trigger only applies to set four, time/step or temperature record
   assign time_trig = (time_step_trigger_sel && !data_valid_sel) ?
                      step_edge : rate_edge;                   // RULE_13

   sensor_fifo_packer u_packer
   (
      .high_only (high_part_only),
      .kind      (kind),
      .set4_sel  (state_reg == ST_SET4),
      .byte_idx  (byte_reg),
      .smp       (smp_reg),
      .byte_out  (pick)
   );

   // Sequencer next state; one byte per clock
   always_comb
   begin
      state_next = state_reg;
      byte_next  = byte_reg;
      dec1_next  = dec1_reg;
      dec4_next  = dec4_reg;
      want4_next = want4_reg;
      lo_next    = lo_reg;
      half_next  = half_reg;
      smp_next   = smp_reg;
      push       = 1'b0;
      push_word  = {pick, lo_reg};
      case (state_reg)
         ST_IDLE:
         begin
            // Mode field gates storage; host writes it last
            if (operating_mode != `SF_MODE_BYPASS) // RULE_17
            begin
               if (rate_edge && dec_hit(set1_decimation, dec1_reg))
                  state_next = ST_SET1;
               if (rate_edge)
                  dec1_next = dec_hit(set1_decimation, dec1_reg) ?
                              3'h0 : 3'(dec1_reg + 3'h1);
               if (set4_on && time_trig)
               begin
                  // Set four decimation applies to records
                  want4_next = dec_hit(set4_decimation, dec4_reg); // RULE_12
                  dec4_next  = want4_next ? 3'h0 : 3'(dec4_reg + 3'h1);
                  if (want4_next && !(rate_edge &&
                      dec_hit(set1_decimation, dec1_reg)))
                     state_next = ST_SET4;
               end
               if (state_next != ST_IDLE)
               begin
                  smp_next  = sample;
                  byte_next = 3'h0;
                  half_next = 1'b0;
               end
            end
         end
         ST_SET1, ST_SET4:
         begin
            // Bytes pair into words, low byte first
            if (half_reg)
               push = 1'b1;
            else
               lo_next = pick;
            half_next = ~half_reg;
            if (byte_reg == 3'(`SF_SET_BYTES - 1))
            begin
               byte_next = 3'h0;
               if (state_reg == ST_SET1 && want4_reg)
                  state_next = ST_SET4;
               else
                  state_next = ST_IDLE;
               if (state_reg == ST_SET4)
                  want4_next = 1'b0;
            end
            else
               byte_next = 3'(byte_reg + 3'h1);
         end
         default:
            state_next = ST_IDLE;
      endcase
   end
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_reg <= ST_IDLE;
         byte_reg  <= 3'h0;
         dec1_reg  <= 3'h0;
         dec4_reg  <= 3'h0;
         want4_reg <= 1'b0;
         lo_reg    <= 8'h00;
         half_reg  <= 1'b0;
         smp_reg   <= '0;
      end
      else
      begin
         state_reg <= state_next;
         byte_reg  <= byte_next;
         dec1_reg  <= dec1_next;
         dec4_reg  <= dec4_next;
         want4_reg <= want4_next;
         lo_reg    <= lo_next;
         half_reg  <= half_next;
         smp_reg   <= smp_next;
      end
   end

   // ------------------------------------------------------------
   // Occupancy and flags
   // ------------------------------------------------------------
   logic [11:0] cnt_reg, cnt_next;
   logic [11:0] cap;
   logic        full, take, drop;
   logic        wm_next, sf_next, strobe_next;
   logic [15:0] data_next;
   logic        wm_reg, sf_reg, strobe_reg;
   logic [15:0] data_reg;

   // Threshold replaces physical size when limited
   assign cap  = limit_at_threshold ? {1'b0, threshold_level} :
                 12'(DEPTH);                                   // RULE_03
   // Outside continuous mode storage stops as smart-full rises, so with the limit set the count
   // stays one word under the threshold and the watermark stays low
   assign full = (12'(cnt_reg + 12'h1) >= cap);                // RULE_06
   // FIFO mode stops one word short of capacity; continuous keeps storing
   assign take = push && (!full || operating_mode == `SF_MODE_CONT); // RULE_04
   assign drop = word_read && (cnt_reg != 12'h0);

   always_comb
   begin
      cnt_next = cnt_reg;
      if (take && !drop && cnt_reg != 12'(DEPTH))
         cnt_next = 12'(cnt_reg + 12'h1);
      else if (drop && !take)
         cnt_next = 12'(cnt_reg - 12'h1);
      // Flags from the new count, so reads clear them at once
      wm_next = (cnt_next >= {1'b0, threshold_level});   // RULE_02 RULE_18
      sf_next = (12'(cnt_next + 12'h1) >= cap);           // RULE_05
      strobe_next = take;
      data_next   = take ? push_word : data_reg;
   end
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cnt_reg    <= 12'h0;
         wm_reg     <= 1'b0;
         sf_reg     <= 1'b0;
         strobe_reg <= 1'b0;
         data_reg   <= 16'h0000;
      end
      else
      begin
         cnt_reg    <= cnt_next;
         wm_reg     <= wm_next;
         sf_reg     <= sf_next;
         strobe_reg <= strobe_next;
         data_reg   <= data_next;
      end
   end
   assign word_count_out  = {4'h0, cnt_reg};
   assign watermark_flag  = wm_reg;
   assign smart_full_flag = sf_reg;
   assign word_strobe     = strobe_reg;
   assign word_data       = data_reg;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_wm;
      @(posedge clk) disable iff (srst)
      1'b1 |=> (watermark_flag == (cnt_reg >= {1'b0, $past(threshold_level)}));
   endproperty
   a_wm: assert property (p_wm) else $error("watermark wrong"); // RULE_02
   property p_sf;
      @(posedge clk) disable iff (srst)
      1'b1 |=> (smart_full_flag == (12'(cnt_reg + 12'h1) >= $past(cap)));
   endproperty
   a_sf: assert property (p_sf) else $error("smart full wrong"); // RULE_05
   property p_stop;
      @(posedge clk) disable iff (srst)
      (operating_mode == `SF_MODE_FIFO && full && !drop) |=>
         (cnt_reg == $past(cnt_reg));
   endproperty
   a_stop: assert property (p_stop) else $error("stored past cap"); // RULE_03
   property p_rd;
      @(posedge clk) disable iff (srst)
      (drop && !take) |=> (cnt_reg == 12'($past(cnt_reg) - 12'h1));
   endproperty
   a_rd: assert property (p_rd) else $error("read not counted"); // RULE_18
   property p_bypass;
      @(posedge clk) disable iff (srst)
      (operating_mode == `SF_MODE_BYPASS && state_reg == ST_IDLE) |=>
         (state_reg == ST_IDLE);
   endproperty
   a_bypass: assert property (p_bypass) else $error("stored in bypass"); // RULE_17
   property p_six;
      @(posedge clk) disable iff (srst)
      ($rose(state_reg == ST_SET4) && $past(state_reg) == ST_IDLE) |->
         (state_reg == ST_SET4) [*6] ##1 (state_reg == ST_IDLE);
   endproperty
   a_six: assert property (p_six) else $error("set four not six"); // RULE_11
   property p_cont;
      @(posedge clk) disable iff (srst)
      (operating_mode == `SF_MODE_CONT && push) |=> word_strobe;
   endproperty
   a_cont: assert property (p_cont) else $error("continuous lost"); // RULE_07
   property p_over;
      @(posedge clk) disable iff (srst)
      (!limit_at_threshold && push && cnt_reg < 12'(DEPTH - 1)) |=>
         word_strobe;
   endproperty
   a_over: assert property (p_over) else $error("stopped early"); // RULE_04
endmodule
`default_nettype wire

// File: logic/sensor_fifo_consts.svh
`ifndef SENSOR_FIFO_CONSTS_SVH
`define SENSOR_FIFO_CONSTS_SVH
// ------------------------------------------------------------
// Sizes and codes
// ------------------------------------------------------------
`define SF_THR_W        11
`define SF_DEPTH        2048
`define SF_CNT_W        12
`define SF_MODE_W       3
`define SF_DEC_W        3
`define SF_DEC_OFF      3'h0
`define SF_MODE_BYPASS  3'h0
`define SF_MODE_FIFO    3'h1
`define SF_MODE_CONT    3'h6
`define SF_SET_BYTES    6
`endif

// File: logic/sensor_fifo_pkg.sv
`default_nettype none
package sensor_fifo_pkg;
   // Packing selected for data set 4
   typedef enum logic [1:0]
   {
      SET4_NONE = 2'b00,
      SET4_TIME = 2'b01,
      SET4_TEMP = 2'b11
   } set4_kind_t;
   // Sampled sensor values for one trigger
   typedef struct packed
   {
      logic [15:0] ax;
      logic [15:0] ay;
      logic [15:0] az;
      logic [15:0] gx;
      logic [15:0] gy;
      logic [15:0] gz;
      logic [23:0] stamp;
      logic [15:0] steps;
      logic [15:0] temp;
   } sensor_sample_t;
   // Status flags seen by the host
   typedef struct packed
   {
      logic        watermark_flag;
      logic        smart_full_flag;
      logic        empty_flag;
      logic [11:0] level;
   } buffer_status_t;
endpackage
`default_nettype wire

// File: logic/sensor_fifo_packer.sv
`include "sensor_fifo_consts.svh"
`default_nettype none
// ------------------------------------------------------------
// Byte packer: chooses the six record bytes of one data set
// ------------------------------------------------------------
module sensor_fifo_packer
(
   input  wire logic                       high_only,
   input  wire sensor_fifo_pkg::set4_kind_t kind,
   input  wire logic                       set4_sel,
   input  wire logic [2:0]                 byte_idx,
   input  wire sensor_fifo_pkg::sensor_sample_t smp,
   output logic [7:0]                      byte_out
);
   // Combinational byte pick
   always_comb
   begin
      byte_out = 8'h00;
      if (set4_sel)
      begin
         if (kind == sensor_fifo_pkg::SET4_TIME)
         begin
            case (byte_idx) // RULE_11
               3'h0:    byte_out = smp.stamp[15:8];
               3'h1:    byte_out = smp.stamp[23:16];
               3'h3:    byte_out = smp.stamp[7:0];
               3'h4:    byte_out = smp.steps[7:0];
               3'h5:    byte_out = smp.steps[15:8];
               default: byte_out = 8'h00;
            endcase
         end
         else
         begin
            case (byte_idx) // RULE_15
               3'h2:    byte_out = smp.temp[7:0];
               3'h3:    byte_out = smp.temp[15:8];
               default: byte_out = 8'h00;
            endcase
         end
      end
      else if (high_only) // RULE_08 RULE_10
      begin
         // Interleaved high bytes, accel first
         case (byte_idx) // RULE_09
            3'h0:    byte_out = smp.ax[15:8];
            3'h1:    byte_out = smp.gx[15:8];
            3'h2:    byte_out = smp.ay[15:8];
            3'h3:    byte_out = smp.gy[15:8];
            3'h4:    byte_out = smp.az[15:8];
            default: byte_out = smp.gz[15:8];
         endcase
      end
      else
      begin
         // Full gyro words, low byte first
         case (byte_idx)
            3'h0:    byte_out = smp.gx[7:0];
            3'h1:    byte_out = smp.gx[15:8];
            3'h2:    byte_out = smp.gy[7:0];
            3'h3:    byte_out = smp.gy[15:8];
            3'h4:    byte_out = smp.gz[7:0];
            default: byte_out = smp.gz[15:8];
         endcase
      end
   end
endmodule
`default_nettype wire

// File: bench/sensor_host_model.sv
`default_nettype none
// ------------------------------------------------------------
// Host model: holds the configuration bits and pops words
// ------------------------------------------------------------
module sensor_host_model
(
   input  wire logic        clk,
   output logic [10:0]      threshold_level,
   output logic             limit_at_threshold,
   output logic             high_part_only,
   output logic [2:0]       set1_decimation,
   output logic [2:0]       set4_decimation,
   output logic             time_step_record_en,
   output logic             time_step_trigger_sel,
   output logic             temp_record_en,
   output logic             data_valid_sel,
   output logic [2:0]       operating_mode,
   output logic             word_read
);
   timeunit 1ns;
   timeprecision 1ps;

   // Quiet configuration at time zero: bypass, nothing enabled
   initial
   begin
      {threshold_level, limit_at_threshold, high_part_only} = '0;
      {set1_decimation, set4_decimation, operating_mode} = '0;
      {time_step_record_en, time_step_trigger_sel} = '0;
      {temp_record_en, data_valid_sel, word_read} = '0;
   end

   // One field group per cycle; mode goes back to bypass first so the
   // device never runs on a half-written setup, and is set last
   task automatic configure(input logic [10:0] thr, input logic lim,
                            input logic hp, input logic [2:0] d1,
                            input logic [2:0] d4, input logic ts_en,
                            input logic ts_trig, input logic tmp_en,
                            input logic [2:0] mode);
      @(negedge clk) operating_mode = 3'h0;
      @(negedge clk) set4_decimation = d4;
      @(negedge clk) time_step_record_en = ts_en;
      temp_record_en = tmp_en;
      data_valid_sel = 1'b0;
      @(negedge clk) time_step_trigger_sel = ts_trig;
      // High-part packing: set two is kept off on this port set
      @(negedge clk) high_part_only = hp;
      set1_decimation = d1;
      threshold_level = thr;
      limit_at_threshold = lim;
      @(negedge clk) operating_mode = mode;
      repeat (2) @(negedge clk);
   endtask

   // Pop one word; a one-cycle pulse, then let the flags settle
   task automatic read_word();
      @(negedge clk) word_read = 1'b1;
      @(negedge clk) word_read = 1'b0;
      repeat (2) @(negedge clk);
   endtask
endmodule
`default_nettype wire

// File: bench/tb_sensor_fifo_core.sv
`default_nettype none
module tb_sensor_fifo_core;
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------
   // Signals
   // ---------------------------------------------------------
   localparam int DEPTH = 64;          // Short buffer keeps run brief
   logic        clk, srst, rate_tick, step_detect;
   logic [10:0] threshold_level;
   logic        limit_at_threshold, high_part_only, word_read;
   logic [2:0]  set1_decimation, set4_decimation, operating_mode;
   logic        time_step_record_en, time_step_trigger_sel;
   logic        temp_record_en, data_valid_sel;
   sensor_fifo_pkg::sensor_sample_t sample;
   logic [15:0] word_count_out, word_data;
   logic        watermark_flag, smart_full_flag, word_strobe;
   logic [15:0] got_q[$];              // Words seen on the strobe
   int          n_mismatch, check_count, cycles, i;

   sensor_host_model u_sensor_host_model (.*);
   sensor_fifo_core #(.DEPTH(DEPTH)) u_sensor_fifo_core (.*);

   // ---------------------------------------------------------
   // Clock, timeout and word monitor
   // ---------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Hang guard: whole plan needs well under this many cycles; words are
   // taken mid-cycle, where the strobe and data stand settled
   always @(negedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         complete_run();
      end
      if (word_strobe === 1'b1)
         got_q.push_back(word_data);
   end

   // ---------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h",
                  $time, seen, exp);
      end
   endtask

   // Status flags and count in one go
   task automatic flags(input logic [15:0] cnt, input logic wm,
                        input logic sf);
      check(word_count_out, cnt);
      check({15'h0, watermark_flag}, {15'h0, wm});
      check({15'h0, smart_full_flag}, {15'h0, sf});
   endtask

   // Rising edge on a trigger pin; spacing well past the loss window
   task automatic trig(input logic step);
      @(negedge clk);
      if (step)
         step_detect = 1'b1;
      else
         rate_tick = 1'b1;
      repeat (3) @(negedge clk);
      {rate_tick, step_detect} = 2'b00;
      repeat (20) @(negedge clk);
   endtask

   task automatic do_reset();
      @(negedge clk) srst = 1'b1;
      repeat (5) @(negedge clk);
      srst = 1'b0;
      repeat (2) @(negedge clk);
      got_q.delete();
   endtask

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ---------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------
   initial
   begin
      {srst, rate_tick, step_detect} = 3'b100;
      n_mismatch = 0;
      check_count = 0;
      cycles = 0;
      sample = '{ax: 16'ha1a0, ay: 16'ha3a2, az: 16'ha5a4,
                 gx: 16'hb1b0, gy: 16'hb3b2, gz: 16'hb5b4,
                 stamp: 24'hc3c2c1, steps: 16'hd2d1, temp: 16'he2e1};
      do_reset();
      flags(16'h0000, 1'b1, 1'b0);

      // Threshold 7 without limit: three words per record
      u_sensor_host_model.configure(11'h007, 0, 0, 1, 0, 0, 0, 0, 3'h1);
      trig(0);
      trig(0);
      flags(16'h0006, 1'b0, 1'b0);
      trig(0);
      flags(16'h0009, 1'b1, 1'b0);
      for (i = 3; i < 20; i++)
         trig(0);
      flags(16'h003c, 1'b1, 1'b0);
      trig(0);
      flags(16'h003f, 1'b1, 1'b1);
      check(got_q[20], sample.gz);
      u_sensor_host_model.read_word();
      flags(16'h003e, 1'b1, 1'b0);
      for (i = 0; i < 55; i++)
         u_sensor_host_model.read_word();
      flags(16'h0007, 1'b1, 1'b0);
      u_sensor_host_model.read_word();
      flags(16'h0006, 1'b0, 1'b0);
      $display("test threshold without limit done");

      // FIFO mode, limit set: threshold is the capacity
      do_reset();
      u_sensor_host_model.configure(11'h00a, 1, 0, 1, 0, 0, 0, 0, 3'h1);
      for (i = 0; i < 3; i++)
         trig(0);
      flags(16'h0009, 1'b0, 1'b1);
      trig(0);
      trig(0);
      check({15'h0, watermark_flag}, 16'h0000);
      check({15'h0, word_count_out < 16'h000a}, 16'h0001);
      $display("test fifo mode with limit done");

      // Continuous mode, limit set: smart-full, then watermark
      do_reset();
      u_sensor_host_model.configure(11'h00a, 1, 0, 1, 0, 0, 0, 0, 3'h6);
      for (i = 0; i < 3; i++)
         trig(0);
      flags(16'h0009, 1'b0, 1'b1);
      trig(0);
      check({15'h0, watermark_flag}, 16'h0001);
      $display("test continuous with limit done");

      // Bypass mode stores nothing
      do_reset();
      u_sensor_host_model.configure(11'h00a, 0, 0, 1, 0, 0, 0, 0, 3'h0);
      trig(0);
      check(word_count_out, 16'h0000);
      $display("test bypass done");

      // High-part packing into set one
      do_reset();
      u_sensor_host_model.configure(11'h064, 0, 1, 1, 0, 0, 0, 0, 3'h1);
      trig(0);
      check(word_count_out, 16'h0003);
      check(16'(got_q.size()), 16'h0003);
      check(got_q[0], {sample.gx[15:8], sample.ax[15:8]});
      check(got_q[1], {sample.gy[15:8], sample.ay[15:8]});
      check(got_q[2], {sample.gz[15:8], sample.az[15:8]});
      $display("test high part done");

      // Time/step record in set four, decimation two, rate trigger
      do_reset();
      u_sensor_host_model.configure(11'h064, 0, 0, 0, 2, 1, 0, 0, 3'h1);
      trig(0);
      trig(0);
      check(16'(got_q.size()), 16'h0003);
      check(got_q[0], sample.stamp[23:8]);
      check({8'h00, got_q[1][15:8]}, {8'h00, sample.stamp[7:0]});
      check(got_q[2], sample.steps);
      // Step trigger: rate ticks no longer store the record
      u_sensor_host_model.configure(11'h064, 0, 0, 0, 1, 1, 1, 0, 3'h1);
      trig(0);
      check(16'(got_q.size()), 16'h0003);
      trig(1);
      check(16'(got_q.size()), 16'h0006);
      check(got_q[5], sample.steps);
      $display("test time and step record done");

      // Temperature record in set four
      do_reset();
      u_sensor_host_model.configure(11'h064, 0, 0, 0, 1, 0, 0, 1, 3'h1);
      trig(0);
      check(16'(got_q.size()), 16'h0003);
      check(got_q[1], sample.temp);
      $display("test temperature record done");
      complete_run();
   end
endmodule
`default_nettype wire
